/* File: core/crfr_top.sv */
// Purpose: receiver flag register, state fields, interrupt and foreground gating
// Assumes: error counters, fifo and sleep logic live in the controller outside
// Notes: all state is one struct, one comb fill and one clocked register
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module crfr_top
  import crfr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic initAcknowledge,
  input wire logic sleepMode,
  input wire logic canRx,
  input wire crfr_pkg::crfr_counts_t errorCounts,
  input wire logic overrunEvent,
  input wire logic shiftRequest,
  output logic shiftGrant,
  output logic initRequest,
  output logic wakeEnable,
  output logic irq,
  output crfr_pkg::crfr_irqs_t irqs
);
  import crfr_pkg::*;

  crfr_state_t state;
  crfr_state_t next_state;

  function automatic crfr_reg_t decodeReg(input logic [7:0] addr);
    case (addr)
      OFS_FLAGS: decodeReg = REG_FLAGS;
      OFS_MASK: decodeReg = REG_MASK;
      OFS_CTRL: decodeReg = REG_CTRL;
      default: decodeReg = REG_NONE;
    endcase
  endfunction

  // sensitivity 01 watches bus-off only, 10 adds error level, 11 all changes
  function automatic logic sensitive(input logic [1:0] level, input logic [1:0] oldSt,
                                     input logic [1:0] newSt);
    logic offEdge;
    logic errEdge;
    offEdge = (oldSt == ST_BUSOFF) != (newSt == ST_BUSOFF);
    errEdge = (oldSt >= ST_ERR) != (newSt >= ST_ERR);
    case (level)
      2'h0: sensitive = 1'b0;
      2'h1: sensitive = offEdge;
      2'h2: sensitive = offEdge | errEdge;
      default: sensitive = oldSt != newSt;
    endcase
  endfunction

  logic initActive;
  logic [1:0] txCalc;
  logic [1:0] rxCalc;
  logic stateMoved;
  logic cscSet;
  logic wakeSet;
  logic rxfSet;
  logic doWrite;
  logic [7:0] clr;
  crfr_reg_t wReg;
  crfr_reg_t rReg;
  logic [7:0] flagByte;

  always_comb begin
    next_state = state;
    initActive = state.initRequest & initAcknowledge;
    flagByte = {state.wakeFlag, state.busStatusChangeFlag, state.receiverStateField,
                state.transmitterStateField, state.overrunFlag, state.receiveFullFlag};

    // pin synchroniser, level accepted once stages two and three agree
    next_state.rxSync = {state.rxSync[1:0], canRx};
    if (state.rxSync[1] == state.rxSync[2]) begin
      next_state.canLevel = state.rxSync[2];
    end

    // counter-derived bus state
    if (errorCounts.transmit_error_count > LIM_BUSOFF) begin
      txCalc = ST_BUSOFF;
    end else if (errorCounts.transmit_error_count > LIM_ERR) begin
      txCalc = ST_ERR;
    end else if (errorCounts.transmit_error_count > LIM_WARN) begin
      txCalc = ST_WARN;
    end else begin
      txCalc = ST_OK;
    end
    if (txCalc == ST_BUSOFF) begin
      rxCalc = ST_BUSOFF;
    end else if (state.transmitterStateField == ST_BUSOFF) begin
      rxCalc = ST_OK;
    end else if ({1'b0, errorCounts.receive_error_count} > LIM_ERR) begin
      rxCalc = ST_ERR;
    end else if ({1'b0, errorCounts.receive_error_count} > LIM_WARN) begin
      rxCalc = ST_WARN;
    end else begin
      rxCalc = ST_OK;
    end

    stateMoved = (rxCalc != state.receiverStateField) ||
                 (txCalc != state.transmitterStateField);
    cscSet = 1'b0;
    // fields stay frozen while a status-change is pending
    if (!state.busStatusChangeFlag && stateMoved) begin
      next_state.receiverStateField = rxCalc;
      next_state.transmitterStateField = txCalc;
      cscSet = !initActive &&
               (sensitive(state.mask[5:4], state.receiverStateField, rxCalc) ||
                sensitive(state.mask[3:2], state.transmitterStateField, txCalc));
    end

    wakeSet = sleepMode & state.wakeEnable & ~state.canLevel;
    rxfSet = state.shiftGrant;

    // one grant per free foreground buffer
    next_state.shiftGrant = shiftRequest & ~state.receiveFullFlag & ~state.shiftGrant &
                            ~initActive;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.awHave = 1'b1;
      next_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.wHave = 1'b1;
      next_state.wData = s_axi_wdata[7:0];
      next_state.wByte = s_axi_wstrb[0];
    end
    doWrite = state.awHave && state.wHave && !state.bvalid;
    wReg = decodeReg(state.awAddr);
    clr = 8'h00;
    if (doWrite) begin
      next_state.awHave = 1'b0;
      next_state.wHave = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = (wReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (state.wByte) begin
        case (wReg)
          // clears are ignored until request and acknowledge have both dropped
          REG_FLAGS: clr = (state.initRequest || initAcknowledge) ? 8'h00 : state.wData;
          REG_MASK: next_state.mask = state.wData;
          REG_CTRL: begin
            next_state.initRequest = state.wData[BIT_INITREQ];
            next_state.wakeEnable = state.wData[BIT_WAKEEN];
          end
          default: clr = 8'h00;
        endcase
      end
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    next_state.awready = !next_state.awHave && !next_state.bvalid;
    next_state.wready = !next_state.wHave && !next_state.bvalid;

    // set wins over clear; a still-present cause keeps the flag
    // state bits are not in the clear path
    next_state.wakeFlag = wakeSet | (state.wakeFlag & ~clr[BIT_WAKE]);
    next_state.busStatusChangeFlag = cscSet | (state.busStatusChangeFlag & ~clr[BIT_CSC]);
    next_state.overrunFlag = overrunEvent | (state.overrunFlag & ~clr[BIT_OVR]);
    next_state.receiveFullFlag = rxfSet | (state.receiveFullFlag & ~clr[BIT_RXF]);

    if (initActive) begin
      next_state.wakeFlag = 1'b0;
      next_state.busStatusChangeFlag = 1'b0;
      next_state.overrunFlag = 1'b0;
      next_state.receiveFullFlag = 1'b0;
      next_state.mask = RST_MASK;
    end

    // read channel
    rReg = decodeReg(s_axi_araddr);
    if (s_axi_arvalid && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = (rReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rReg)
        REG_FLAGS: next_state.rdata = {24'h000000, flagByte};
        REG_MASK: next_state.rdata = {24'h000000, state.mask};
        REG_CTRL: next_state.rdata = {29'h00000000, initAcknowledge, state.wakeEnable,
                                      state.initRequest};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end

    // interrupt level follows the registered flags and mask
    next_state.irqs.wakeIrq = next_state.wakeFlag & next_state.mask[BIT_WAKE];
    next_state.irqs.errorIrq = (next_state.busStatusChangeFlag & next_state.mask[BIT_CSC]) |
                               (next_state.overrunFlag & next_state.mask[BIT_OVR]);
    next_state.irqs.receiveIrq = next_state.receiveFullFlag & next_state.mask[BIT_RXF];
    next_state.irq = next_state.irqs.wakeIrq | next_state.irqs.errorIrq |
                     next_state.irqs.receiveIrq;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.mask <= RST_MASK;
      state.receiverStateField <= RST_STATE;
      state.transmitterStateField <= RST_STATE;
      state.rxSync <= 3'h7;
      state.canLevel <= 1'b1;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign shiftGrant = state.shiftGrant;
  assign initRequest = state.initRequest;
  assign wakeEnable = state.wakeEnable;
  assign irq = state.irq;
  assign irqs = state.irqs;

endmodule
`default_nettype wire

/* File: core/crfr_pkg.sv */
// Purpose: constants and types for the receiver flag and status register block
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes: flags are write-one-to-clear; state fields are read-only
// Behaviour
// - while init request and acknowledge are both high, flags held at reset.
// - flags writable again once init request and acknowledge have both returned low.
// - outside init, writing one clears a flag, writing zero leaves it.
// - receiver and transmitter state fields are read-only to writes.
// - state fields keep tracking bus state during init mode.
// - bus activity in sleep with wake enabled sets wake flag, bit 7.
// - a change of counter-derived bus status sets status-change flag, bit 6.
// - while status-change flag is set, state fields stay frozen.
// - receiver field bits 5:4: <=96, <=127, >127, bus-off codes 00..11.
// - transmitter field bits 3:2: <=96, <=127, <=255, >255 codes 00..11.
// - a receive data overrun sets overrun flag, bit 1.
// - a correct message shifted into foreground buffer sets receive-full, bit 0.
// - no foreground shift while receive-full flag is set.
// - each unmasked set flag holds its wake, error or receive interrupt.
// - bus-off forces receiver to bus-off; leaving it sends receiver to error-free.
// - a clear write loses while the setting condition still holds.
package crfr_pkg;

  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;

  localparam int BIT_WAKE = 7;
  localparam int BIT_CSC = 6;
  localparam int BIT_RECEIVER_STATE_FIELD = 4;
  localparam int BIT_TRANSMITTER_STATE_FIELD = 2;
  localparam int BIT_OVR = 1;
  localparam int BIT_RXF = 0;
  localparam int BIT_INITREQ = 0;
  localparam int BIT_WAKEEN = 1;

  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [1:0] RST_STATE = 2'h0;

  localparam logic [8:0] LIM_WARN = 9'h060;
  localparam logic [8:0] LIM_ERR = 9'h07f;
  localparam logic [8:0] LIM_BUSOFF = 9'h0ff;

  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_ERR = 2'h2;
  localparam logic [1:0] ST_BUSOFF = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REG_FLAGS,
    REG_MASK,
    REG_CTRL,
    REG_NONE
  } crfr_reg_t;

  typedef struct packed {
    logic [8:0] transmit_error_count;
    logic [7:0] receive_error_count;
  } crfr_counts_t;

  typedef struct packed {
    logic wakeIrq;
    logic errorIrq;
    logic receiveIrq;
  } crfr_irqs_t;

  typedef struct packed {
    logic wakeFlag;
    logic busStatusChangeFlag;
    logic [1:0] receiverStateField;
    logic [1:0] transmitterStateField;
    logic overrunFlag;
    logic receiveFullFlag;
    logic [7:0] mask;
    logic initRequest;
    logic wakeEnable;
    logic [2:0] rxSync;
    logic canLevel;
    logic shiftGrant;
    logic awready;
    logic wready;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [7:0] wData;
    logic wByte;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    crfr_irqs_t irqs;
  } crfr_state_t;

endpackage

/* File: verif/crfr_checker.sv */
// Purpose: port assertions for the receiver flag block
// Assumes: masks are written before the events they enable
// Notes: flags are seen here only through the interrupt levels
`timescale 1ns/1ps
`default_nettype none
module crfr_checker
  import crfr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic initAcknowledge,
  input wire logic sleepMode,
  input wire logic shiftRequest,
  input wire logic shiftGrant,
  input wire logic initRequest,
  input wire logic wakeEnable,
  input wire logic irq,
  input wire crfr_pkg::crfr_irqs_t irqs
);
  import crfr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst |-> !irq && !shiftGrant)
    else $error("output active in reset");
  AST_IRQ_OR: assert property (irq == (irqs.wakeIrq || irqs.errorIrq || irqs.receiveIrq))
    else $error("irq differs from its sources");
  AST_INIT_QUIET: assert property ((initRequest && initAcknowledge) [*2] |-> !irq && !shiftGrant)
    else $error("activity in init mode");
  AST_GRANT_CAUSE: assert property (shiftGrant |-> $past(shiftRequest))
    else $error("grant without request");
  // a clear right behind the grant may legally allow the next one three cycles on
  AST_GRANT_BLOCK: assert property (shiftGrant |=> !shiftGrant [*2])
    else $error("grant while buffer full");
  AST_GRANT_FREE: assert property (shiftGrant |-> !irqs.receiveIrq)
    else $error("grant with receive pending");
  AST_WAKE_CAUSE: assert property ($rose(irqs.wakeIrq) |-> $past(sleepMode) && $past(wakeEnable))
    else $error("wake outside sleep");
  AST_RX_CAUSE: assert property ($rose(irqs.receiveIrq) |-> $past(shiftGrant))
    else $error("receive irq without shift");
  COV_GRANT: cover property (shiftGrant);
  COV_WAKE: cover property (irqs.wakeIrq);
  COV_ERROR: cover property (irqs.errorIrq);
endmodule
bind crfr_top crfr_checker i_crfr_checker (.clock, .rst, .initAcknowledge, .sleepMode,
  .shiftRequest, .shiftGrant, .initRequest, .wakeEnable, .irq, .irqs);
`default_nettype wire

/* File: verif/crfr_can_model.sv */
// Purpose: far side stand-in: bus line, error counters, overrun, receive fifo
// Assumes: the bus line idles recessive high
// Notes: the fifo offers a message until the block grants the shift
`timescale 1ns/1ps
`default_nettype none
module crfr_can_model
  import crfr_pkg::*;
(
  input wire logic clock,
  input wire logic shiftGrant,
  output logic canRx,
  output crfr_pkg::crfr_counts_t errorCounts,
  output logic overrunEvent,
  output logic shiftRequest
);
  import crfr_pkg::*;
  int queued = 0;
  int taken = 0;
  initial begin
    canRx = 1'b1;
    errorCounts = '0;
    overrunEvent = 1'b0;
  end
  assign shiftRequest = queued != taken;
  always @(posedge clock) begin
    if (shiftGrant) taken <= taken + 1; // entry leaves only on a grant
  end
  task automatic pulse(input bit bus, input int n);
    @(posedge clock);
    if (bus) canRx <= 1'b0; else overrunEvent <= 1'b1;
    repeat (n) @(posedge clock);
    canRx <= 1'b1;
    overrunEvent <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/crfr_top_test.sv */
// Purpose: self-checking bench for the receiver flag block
// Assumes: init acknowledge follows init request one cycle later
// Notes: bus tasks sample at the falling edge, drive at the rising one
`timescale 1ns/1ps
`default_nettype none
module crfr_top_test;
  import crfr_pkg::*;
  logic clock = 0, rst = 0, initAcknowledge = 0, sleepMode = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, canRx, overrunEvent, shiftRequest, shiftGrant, initRequest, wakeEnable, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  crfr_counts_t errorCounts;
  crfr_irqs_t irqs;
  logic [8:0] corner [8] = '{9'h000, 9'h060, 9'h061, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h1ff};
  int n_errors = 0, cmp_count = 0, cyc = 0, grants = 0, seed = 32'hfa63;
  crfr_top i_crfr_top (.*);
  crfr_can_model i_crfr_can_model (.clock, .shiftGrant, .canRx, .errorCounts, .overrunEvent,
    .shiftRequest);
  initial forever #20 clock = ~clock;
  always @(posedge clock) begin
    initAcknowledge <= initRequest;
    cyc <= cyc + 1;
    grants <= grants + shiftGrant;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = RESP_OKAY);
    logic aw, w, b;
    logic [1:0] rs;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    b = 0;
    while (!b) begin
      @(negedge clock);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("bresp", er, rs);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar, r;
    logic [1:0] rs;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    r = 0;
    while (!r) begin
      @(negedge clock);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check("rresp", er, rs);
  endtask
  task automatic expect_reg(input string what, input logic [7:0] a, exp);
    logic [31:0] d;
    rd(a, d, RESP_OKAY);
    check(what, {24'h0, exp}, d);
  endtask
  task automatic setc(input crfr_counts_t v);
    @(posedge clock);
    i_crfr_can_model.errorCounts <= v;
    repeat (3) @(posedge clock);
  endtask
  // bus-off overrides rx; the first update after leaving it reports rx ok
  function automatic logic [3:0] fields(crfr_counts_t c, logic wasOff);
    logic [1:0] t, r;
    t = c.transmit_error_count > LIM_BUSOFF ? ST_BUSOFF : c.transmit_error_count > LIM_ERR ? ST_ERR : c.transmit_error_count > LIM_WARN ? ST_WARN : ST_OK;
    r = c.receive_error_count > LIM_ERR ? ST_ERR : c.receive_error_count > LIM_WARN ? ST_WARN : ST_OK;
    return t == ST_BUSOFF ? 4'hf : wasOff ? {2'h0, t} : {r, t};
  endfunction
  initial begin
    logic [31:0] d, k;
    logic [3:0] expF, prevF;
    crfr_counts_t c;
    // a real rising edge so the asynchronous reset acts before the first clock
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    expect_reg("flags", OFS_FLAGS, 8'h00);
    expect_reg("mask", OFS_MASK, 8'h00);
    rd(8'h0c, d, RESP_SLVERR);
    wr(8'h0c, 8'hff, RESP_SLVERR);
    i_crfr_can_model.pulse(0, 1);
    expect_reg("ovr", OFS_FLAGS, 8'h02);
    check("irq masked", 0, irq);
    wr(OFS_MASK, 8'hff);
    wr(OFS_FLAGS, 8'h00);
    check("irq", 1, irq);
    check("errIrq", 1, irqs.errorIrq);
    fork
      i_crfr_can_model.pulse(0, 12);
      wr(OFS_FLAGS, 8'h02);
    join
    expect_reg("ovr held", OFS_FLAGS, 8'h02);
    wr(OFS_FLAGS, 8'h02);
    expect_reg("ovr clr", OFS_FLAGS, 8'h00);
    check("irq clr", 0, irq);
    @(posedge clock) i_crfr_can_model.queued <= 2;
    repeat (10) @(posedge clock);
    check("grants", 1, grants);
    expect_reg("rxf", OFS_FLAGS, 8'h01);
    check("rxIrq", 1, irqs.receiveIrq);
    wr(OFS_FLAGS, 8'h01);
    repeat (6) @(posedge clock);
    check("grants2", 2, grants);
    wr(OFS_FLAGS, 8'h01);
    prevF = 4'h0;
    for (int i = 0; i < 30; i++) begin
      k = $random(seed);
      c.transmit_error_count = k[3] ? corner[k[2:0]] : k[24:16];
      c.receive_error_count = k[4] ? corner[k[7:5]][7:0] : k[31:24];
      setc(c);
      expF = fields(c, prevF[1:0] == ST_BUSOFF);
      expect_reg("state", OFS_FLAGS, {1'b0, expF != prevF, expF, 2'b00});
      wr(OFS_FLAGS, 8'h7c);
      // after a bus-off exit the receiver field catches up on the next update
      prevF = fields(c, 1'b0);
      if (prevF != expF) begin
        expect_reg("catchup", OFS_FLAGS, {2'b01, prevF, 2'b00});
        wr(OFS_FLAGS, 8'h40);
      end
    end
    i_crfr_can_model.pulse(0, 1);
    wr(OFS_CTRL, 8'h01);
    check("initRequest", 1, initRequest);
    c = '{transmit_error_count: 9'h061, receive_error_count: 8'h61};
    setc(c);
    // no freeze in init, so the fields settle on the plain counter decode
    expF = fields(c, 1'b0);
    expect_reg("init", OFS_FLAGS, {2'b00, expF, 2'b00});
    expect_reg("ctrl", OFS_CTRL, 8'h05);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MASK, 8'hff);
    i_crfr_can_model.pulse(0, 1);
    expect_reg("exit", OFS_FLAGS, {2'b00, expF, 2'b10});
    wr(OFS_FLAGS, 8'h02);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL, {6'h0, e[0], 1'b0});
      check("wakeEnable", e, wakeEnable);
      sleepMode <= 1'b1;
      i_crfr_can_model.pulse(1, 6);
      repeat (6) @(posedge clock);
      expect_reg("wake", OFS_FLAGS, {e[0], 1'b0, expF, 2'b00});
      check("wakeIrq", e, irqs.wakeIrq);
      sleepMode <= 1'b0;
      wr(OFS_FLAGS, 8'h80);
    end
    // sensitivity 01 ignores an error-level move, 10 reports it
    wr(OFS_MASK, 8'h10);
    setc('{transmit_error_count: 9'h080, receive_error_count: 8'h80});
    expect_reg("sens off", OFS_FLAGS, 8'h28);
    wr(OFS_MASK, 8'h20);
    setc('{transmit_error_count: 9'h080, receive_error_count: 8'h61});
    expect_reg("sens err", OFS_FLAGS, 8'h58);
    wr(OFS_FLAGS, 8'h40);
    wr(OFS_MASK, 8'hff);
    setc('{transmit_error_count: 9'h100, receive_error_count: 8'h00});
    setc('{transmit_error_count: 9'h000, receive_error_count: 8'h00});
    expect_reg("frozen", OFS_FLAGS, 8'h7c);
    report_and_stop();
  end
endmodule
`default_nettype wire
